// ==== verilog/hotswap_consts.vh ====
// Summary of operation
// (R1) No gate drive before startup and lockout clear
// (R2) Lockout or startup reset grounds drive, power_limit_set, timer
// (R3) Lockout or startup reset releases both flags
// (R4) Allowed current clamped to fixed limit
// (R5) Strong pull-down for OV or big overcurrent
// (R6) Enable gates drive; loss uses weak pull-down
// (R7) Enable low-then-high clears latched off state
// (R8) Power_limit_set grounded when disabled or latched off
// (R9) Full on below limit, else regulate
// (R10) Timer charges while limiting, discharges otherwise
// (R11) Timer at top: strong pull-down, discharge
// (R12) Latching mode stays off until enable cycle
// (R13) Retry: discharge, 15 cycles, then re-enable
// (R14) Timer grounded when disabled or in reset
// (R15) Power good after low drain voltage, 9 ms
// (R16) Power good released on disable, high Vds
// (R17) Deglitch filters brief power good dropouts
// (R18) Fault flag on timer expiry or overvoltage
// (R19) Fault flag released when disabled or reset
// (R20) Fault latched, or cleared when retry re-enables
// (R21) Overvoltage holds drive and fault low
// (R22) Strong pull-down at most 100 us in OV
// (R23) Timing from internal clock; inputs synchronised
`ifndef HOTSWAP_CONSTS_VH
`define HOTSWAP_CONSTS_VH
`define CLK_HZ           50000000
`define PG_DEGLITCH_US   9000
`define OV_STRONG_US     100
`define PG_DEGLITCH_CYC  ((`CLK_HZ / 1000000) * `PG_DEGLITCH_US)
`define OV_STRONG_CYC    ((`CLK_HZ / 1000000) * `OV_STRONG_US)
`define RETRY_CYCLES     15
`define GATE_OFF         2'b00
`define GATE_WEAK_PD     2'b01
`define GATE_STRONG_PD   2'b10
`define GATE_DRIVE       2'b11
`endif

// ==== verilog/sync2.v ====
module sync2 #(
    parameter W = 8
) (
    input  wire         i_ref_clk, // System clock
    input  wire         i_sys_rst, // Synchronous reset
    input  wire [W-1:0] i_async,   // Asynchronous inputs
    output reg  [W-1:0] o_sync     // Synchronised inputs
);
    reg [W-1:0] meta_r;

    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            meta_r <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ==== verilog/hotswap_fault_sequencer.v ====
`include "hotswap_consts.vh"

module hotswap_fault_sequencer #(
    parameter PG_DEGLITCH_CYC = `PG_DEGLITCH_CYC,
    parameter OV_STRONG_CYC   = `OV_STRONG_CYC,
    parameter RETRY_CYCLES    = `RETRY_CYCLES
) (
    input  wire       i_ref_clk,        // 50 MHz clock
    input  wire       i_sys_rst,        // Synchronous reset, high
    input  wire       i_latch_mode,     // 1 latch-off, 0 retry
    input  wire       i_por_ok,         // Supply above POR level
    input  wire       i_supply_low_lockout_ok,        // Supply above lockout level
    input  wire       i_enable_hi,      // enable_undervolt_in above +thr
    input  wire       i_enable_lo,      // enable_undervolt_in below -thr
    input  wire       i_excess_voltage, // excess_voltage_input high
    input  wire       i_over_limit,     // Drain current at allowed value
    input  wire       i_large_overcur,  // Large overcurrent comparator
    input  wire       i_vds_above_clamp,// Vds high: power limit governs
    input  wire       i_vds_low,        // Vds below 1.25 V
    input  wire       i_vds_high,       // Vds above 2.7 V
    input  wire       i_timer_top,      // Timer node at 4 V
    input  wire       i_timer_bottom,   // Timer node at 1 V
    output reg  [1:0] o_gate_mode,      // fet_drive mode
    output reg        o_regulate,       // Gate amp regulating
    output reg        o_limit_clamp,    // Allowed current at 50 mV cap
    output reg        o_timer_charge,   // 27 uA charge on
    output reg        o_timer_discharge,// 2.7 uA discharge on
    output reg        o_timer_ground,   // Timer node grounded
    output reg        o_power_limit_set_ground,    // power_limit_set grounded
    output reg        o_pg_n_out,       // power_good_n output value
    output reg        o_pg_n_oe,        // power_good_n drive enable
    output reg        o_fault_n_out,    // fault_n output value
    output reg        o_fault_n_oe      // fault_n drive enable
);
    localparam ST_OFF     = 5'b00001;
    localparam ST_ON      = 5'b00010;
    localparam ST_LATCHED = 5'b00100;
    localparam ST_RDIS    = 5'b01000;
    localparam ST_RCYC    = 5'b10000;

    wire [10:0] s;
    sync2 #(.W(11)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_por_ok, i_supply_low_lockout_ok, i_enable_hi, i_enable_lo,
                     i_excess_voltage, i_over_limit, i_large_overcur,
                     i_vds_above_clamp, i_vds_low, i_vds_high,
                     i_timer_top}),
        .o_sync    (s)
    );
    wire por_ok   = s[10];
    wire supply_low_lockout_ok  = s[9];
    wire en_hi    = s[8];
    wire en_lo    = s[7];
    wire ov       = s[6];
    wire over_lim = s[5];
    wire big_oc   = s[4];
    wire vds_clmp = s[3];
    wire vds_low  = s[2];
    wire vds_high = s[1];
    wire t_top    = s[0];

    reg bot_meta_r;
    reg t_bot_r;
    // Mode strap is a pin too, so it is synchronised like the rest
    reg latch_meta_r;
    reg latch_r;

    reg [4:0]  state_r;
    reg [4:0]  state_nxt;
    reg        enabled_r;
    reg        enabled_nxt;
    reg        fault_r;
    reg        fault_nxt;
    reg [4:0]  cyc_cnt_r;
    reg [4:0]  cyc_cnt_nxt;
    reg        charging_r;
    reg        charging_nxt;
    reg [23:0] pg_cnt_r;
    reg        pg_good_r;
    reg [23:0] ov_cnt_r;

    wire supply_ok = por_ok & supply_low_lockout_ok; // R1
    wire run = supply_ok & enabled_r;
    // Last of the restart timing cycles
    wire last_cycle = (cyc_cnt_r == RETRY_CYCLES[4:0] - 5'd1); // R13

    // Counter step shared by the deglitch and pull-down timers
    function [23:0] inc24;
        input [23:0] v;
        begin
            inc24 = v + 24'h00_0001;
        end
    endfunction

    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            bot_meta_r   <= 1'b0;
            t_bot_r      <= 1'b0;
            latch_meta_r <= 1'b0;
            latch_r      <= 1'b0;
        end
        else
        begin
            bot_meta_r   <= i_timer_bottom;
            t_bot_r      <= bot_meta_r;
            latch_meta_r <= i_latch_mode;
            latch_r      <= latch_meta_r;
        end
    end

    // Enable hysteresis and sequencing
    always @*
    begin
        state_nxt    = state_r;
        enabled_nxt  = enabled_r;
        fault_nxt    = fault_r;
        cyc_cnt_nxt  = cyc_cnt_r;
        charging_nxt = charging_r;
        if (en_hi)
            enabled_nxt = 1'b1; // R6
        else if (en_lo)
            enabled_nxt = 1'b0; // R6
        if (!supply_ok || !enabled_r)
        begin
            // Also clears a latch-off: enable cycle or lockout, R7 R12
            state_nxt = ST_OFF;
            fault_nxt = 1'b0; // R19
        end
        else
        begin
            case (state_r)
                ST_OFF:
                    state_nxt = ST_ON;
                ST_ON:
                    if (t_top)
                    begin
                        fault_nxt = 1'b1; // R18
                        state_nxt = latch_r ? ST_LATCHED : ST_RDIS;
                    end
                ST_LATCHED:
                    state_nxt = ST_LATCHED; // R12
                ST_RDIS:
                    if (t_bot_r)
                    begin
                        state_nxt    = ST_RCYC; // R13
                        cyc_cnt_nxt  = 5'd0;
                        charging_nxt = 1'b1;
                    end
                ST_RCYC:
                    if (charging_r && t_top)
                        charging_nxt = 1'b0;
                    else if (!charging_r && t_bot_r)
                    begin
                        if (last_cycle)
                        begin
                            state_nxt = ST_ON; // R13
                            fault_nxt = 1'b0;  // R20
                        end
                        else
                        begin
                            cyc_cnt_nxt  = cyc_cnt_r + 5'd1;
                            charging_nxt = 1'b1;
                        end
                    end
                default:
                    state_nxt = ST_OFF;
            endcase
        end
    end

    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            state_r    <= ST_OFF;
            enabled_r  <= 1'b0;
            fault_r    <= 1'b0;
            cyc_cnt_r  <= 5'd0;
            charging_r <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            enabled_r  <= enabled_nxt;
            fault_r    <= fault_nxt;
            cyc_cnt_r  <= cyc_cnt_nxt;
            charging_r <= charging_nxt;
        end
    end

    // Strong pull-down time limit during overvoltage
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst || !ov)
            ov_cnt_r <= 24'h00_0000;
        else if (ov_cnt_r < OV_STRONG_CYC[23:0])
            ov_cnt_r <= inc24(ov_cnt_r); // R22
    end

    // Assert side needs 9 ms of low Vds; release side also deglitched
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst || !run)
        begin
            pg_cnt_r  <= 24'h00_0000;
            pg_good_r <= 1'b0; // R16
        end
        else if (pg_good_r ? vds_high : vds_low)
        begin
            if (pg_cnt_r >= PG_DEGLITCH_CYC[23:0] - 24'h00_0001)
            begin
                pg_good_r <= ~pg_good_r; // R15 R17
                pg_cnt_r  <= 24'h00_0000;
            end
            else
                pg_cnt_r <= inc24(pg_cnt_r);
        end
        else
            pg_cnt_r <= 24'h00_0000; // R17
    end

    wire on_state = (state_r == ST_ON);
    wire expired  = on_state & t_top; // R11
    wire limiting = on_state & over_lim & ~ov;
    // Startup and retry wait also keep the gate hard off
    wire hard_off = expired | (on_state & big_oc) | ~on_state; // R5 R11

    // Overvoltage first, then enable loss, then hard faults
    function [1:0] gate_sel;
        input surge;
        input strong_ok;
        input en;
        input kill;
        begin
            if (surge)
                gate_sel = strong_ok ? `GATE_STRONG_PD : `GATE_WEAK_PD;
            else if (!en)
                gate_sel = `GATE_WEAK_PD;
            else if (kill)
                gate_sel = `GATE_STRONG_PD;
            else
                gate_sel = `GATE_DRIVE;
        end
    endfunction

    // Retry cycling drives the timer itself
    function timer_up;
        input       lim;
        input       top;
        input [4:0] st;
        input       chg;
        begin
            // Stop charging at the top so expiry discharges at once
            timer_up = (lim & ~top) | ((st == ST_RCYC) & chg);
        end
    endfunction

    // Charge and discharge are never both on
    wire tmr_up = timer_up(limiting, t_top, state_r, charging_r); // R10

    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst || !supply_ok)
        begin
            o_gate_mode       <= `GATE_OFF;       // R2
            o_regulate        <= 1'b0;
            o_limit_clamp     <= 1'b0;
            o_timer_charge    <= 1'b0;
            o_timer_discharge <= 1'b0;
            o_timer_ground    <= 1'b1;            // R2
            o_power_limit_set_ground     <= 1'b1;            // R2
            o_pg_n_out        <= 1'b1;
            o_pg_n_oe         <= 1'b0;            // R3
            o_fault_n_out     <= 1'b1;
            o_fault_n_oe      <= 1'b0;            // R3
        end
        else
        begin
            // Strong pull-down only for a bounded time in overvoltage
            o_gate_mode <= gate_sel(ov, ov_cnt_r < OV_STRONG_CYC[23:0],
                                    enabled_r, hard_off); // R5 R6 R21 R22
            o_regulate     <= limiting;                         // R9
            o_limit_clamp  <= ~vds_clmp;                        // R4
            o_timer_charge    <= run & tmr_up;                  // R10
            o_timer_discharge <= run & ~tmr_up;                 // R10
            o_timer_ground <= ~enabled_r;                       // R14
            o_power_limit_set_ground  <= ~run | (state_r == ST_LATCHED);   // R8
            o_pg_n_out     <= 1'b0;
            o_pg_n_oe      <= pg_good_r;                        // R15 R16
            o_fault_n_out  <= 1'b0;
            o_fault_n_oe   <= enabled_r & (fault_r | ov);       // R18 R21
        end
    end
endmodule

// ==== verification/hotswap_fault_sequencer_properties.sv ====
module hotswap_fault_sequencer_properties #(
    parameter PG_DEGLITCH_CYC = 20,
    parameter OV_STRONG_CYC   = 8
) (
    input wire logic       i_ref_clk,        // Clock
    input wire logic       i_sys_rst,        // Reset
    input wire logic       i_por_ok,         // Watched
    input wire logic       i_supply_low_lockout_ok,        // Watched
    input wire logic       i_enable_hi,      // Watched
    input wire logic       i_enable_lo,      // Watched
    input wire logic       i_excess_voltage, // Watched
    input wire logic       i_over_limit,     // Watched
    input wire logic       i_vds_low,        // Watched
    input wire logic       i_timer_top,      // Watched
    input wire logic [1:0] o_gate_mode,      // Watched
    input wire logic       o_timer_charge,   // Watched
    input wire logic       o_timer_ground,   // Watched
    input wire logic       o_power_limit_set_ground,    // Watched
    input wire logic       o_pg_n_oe,        // Watched
    input wire logic       o_fault_n_oe      // Watched
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ov_cnt;
    logic [19:0] low_cnt;
    wire         sup_on = i_por_ok && i_supply_low_lockout_ok && i_enable_hi;
    // Saturating run lengths of raw inputs
    always @(posedge i_ref_clk)
    begin
        ov_cnt <= (i_sys_rst || !(sup_on && i_excess_voltage)) ? 16'h0000 :
                  ov_cnt + {15'h0000, ov_cnt != 16'hffff};
        low_cnt <= (i_sys_rst || !i_vds_low) ? 20'h0_0000 :
                   low_cnt + {19'h0_0000, low_cnt != 20'hf_ffff};
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_dis; i_enable_lo [*6]; endsequence
    sequence s_expire; o_gate_mode == 2'h3 && i_timer_top; endsequence
    sequence s_limit;
        (sup_on && i_over_limit && !i_timer_top && !i_excess_voltage) [*6];
    endsequence
    property p_lockout; (!i_supply_low_lockout_ok) [*6] |-> o_power_limit_set_ground &&
        o_timer_ground && o_gate_mode != 2'h3; endproperty
    a_lockout: assert property (p_lockout) else $error("lockout out");
    property p_por; (!i_por_ok) [*6] |-> !o_pg_n_oe && !o_fault_n_oe;
    endproperty
    a_por: assert property (p_por) else $error("flags driven");
    property p_ov; ov_cnt == 16'h0006 |-> o_fault_n_oe &&
        o_gate_mode == 2'h2; endproperty
    a_ov: assert property (p_ov) else $error("overvoltage out");
    property p_ov_weak; ov_cnt == OV_STRONG_CYC + 8 |-> o_gate_mode == 2'h1;
    endproperty
    a_ov_weak: assert property (p_ov_weak) else $error("strong too long");
    property p_pg_set; $rose(o_pg_n_oe) |-> low_cnt >= PG_DEGLITCH_CYC;
    endproperty
    a_pg_set: assert property (p_pg_set) else $error("good too early");
    property p_pg_rel; s_dis |-> !o_pg_n_oe; endproperty
    a_pg_rel: assert property (p_pg_rel) else $error("good held");
    property p_flt_rel; s_dis |-> !o_fault_n_oe; endproperty
    a_flt_rel: assert property (p_flt_rel) else $error("fault held");
    property p_tmr_dis; s_dis |-> o_timer_ground && !o_timer_charge;
    endproperty
    a_tmr_dis: assert property (p_tmr_dis) else $error("timer on");
    property p_expire; s_expire |-> ##[1:6] (o_gate_mode == 2'h2 &&
        o_fault_n_oe); endproperty
    a_expire: assert property (p_expire) else $error("no expiry");
    property p_charge; s_limit |-> o_timer_charge; endproperty
    a_charge: assert property (p_charge) else $error("no charge");
endmodule
bind hotswap_fault_sequencer hotswap_fault_sequencer_properties #(
    .PG_DEGLITCH_CYC(PG_DEGLITCH_CYC), .OV_STRONG_CYC(OV_STRONG_CYC)
) u_props (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_por_ok(i_por_ok),
    .i_supply_low_lockout_ok(i_supply_low_lockout_ok), .i_enable_hi(i_enable_hi),
    .i_enable_lo(i_enable_lo), .i_excess_voltage(i_excess_voltage),
    .i_over_limit(i_over_limit), .i_vds_low(i_vds_low),
    .i_timer_top(i_timer_top), .o_gate_mode(o_gate_mode),
    .o_timer_charge(o_timer_charge), .o_timer_ground(o_timer_ground),
    .o_power_limit_set_ground(o_power_limit_set_ground), .o_pg_n_oe(o_pg_n_oe),
    .o_fault_n_oe(o_fault_n_oe)
);

// ==== verification/hotswap_fet_model.sv ====
module hotswap_fet_model (
    input  wire logic       i_ref_clk,    // Clock
    input  wire logic [1:0] i_gate_mode,  // Gate mode
    input  wire logic       i_charge,     // Timer charge
    input  wire logic       i_discharge,  // Timer discharge
    input  wire logic       i_ground,     // Timer ground
    input  wire logic       i_short,      // Load short
    output wire logic       o_over_limit, // Limiting
    output wire logic       o_vds_low,    // Low Vds
    output wire logic       o_vds_high,   // High Vds
    output wire logic       o_timer_top,  // Timer at top
    output wire logic       o_timer_bottom // Timer at bottom
);
    timeunit 1ns;
    timeprecision 1ns;
    // Timer node in 10 mV steps
    logic [8:0] level_r = 9'h000;
    wire        on = i_gate_mode == 2'h3;
    always @(posedge i_ref_clk)
    begin
        level_r <= i_ground ? 9'h000 :
                   (i_charge && level_r < 9'h1c2) ? level_r + 9'h00a :
                   (i_discharge && level_r != 9'h000) ? level_r - 9'h001 :
                   level_r;
    end
    assign o_timer_top    = level_r >= 9'h190;
    assign o_timer_bottom = level_r <= 9'h064;
    assign o_over_limit   = on && i_short;
    assign o_vds_low      = on && !i_short;
    assign o_vds_high     = !o_vds_low;
endmodule

// ==== verification/test_hotswap_fault_sequencer.sv ====
module test_hotswap_fault_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam OV_CYC = 8;
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_latch_mode = 1'b0;
    logic i_por_ok = 1'b0, i_supply_low_lockout_ok = 1'b0, i_excess_voltage = 1'b0;
    logic i_enable_hi = 1'b1, i_enable_lo = 1'b0, i_large_overcur = 1'b0;
    logic i_vds_above_clamp = 1'b0, short_r = 1'b0;
    wire  over_limit, vds_low, vds_high, t_top, t_bot, t_chg, t_dis, t_gnd;
    wire  power_limit_set_gnd, pg_oe, f_oe, regl, lclamp, pg_out, f_out;
    logic [2:0] clamp_hist = 3'h0;
    wire  [1:0] gate;
    logic [9:0] notes[$];
    logic [9:0] note;
    int   n_errors = 0, total_checks = 0, n_wait;
    hotswap_fault_sequencer #(
        .PG_DEGLITCH_CYC(20), .OV_STRONG_CYC(OV_CYC), .RETRY_CYCLES(15)
    ) u_dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_latch_mode(i_latch_mode), .i_por_ok(i_por_ok),
        .i_supply_low_lockout_ok(i_supply_low_lockout_ok), .i_enable_hi(i_enable_hi),
        .i_enable_lo(i_enable_lo), .i_excess_voltage(i_excess_voltage),
        .i_over_limit(over_limit), .i_large_overcur(i_large_overcur),
        .i_vds_above_clamp(i_vds_above_clamp), .i_vds_low(vds_low),
        .i_vds_high(vds_high), .i_timer_top(t_top), .i_timer_bottom(t_bot),
        .o_gate_mode(gate), .o_regulate(regl), .o_limit_clamp(lclamp),
        .o_timer_charge(t_chg), .o_timer_discharge(t_dis),
        .o_timer_ground(t_gnd), .o_power_limit_set_ground(power_limit_set_gnd),
        .o_pg_n_out(pg_out), .o_pg_n_oe(pg_oe), .o_fault_n_out(f_out),
        .o_fault_n_oe(f_oe)
    );
    hotswap_fet_model u_fet (
        .i_ref_clk(i_ref_clk), .i_gate_mode(gate), .i_charge(t_chg),
        .i_discharge(t_dis), .i_ground(t_gnd), .i_short(short_r),
        .o_over_limit(over_limit), .o_vds_low(vds_low),
        .o_vds_high(vds_high), .o_timer_top(t_top), .o_timer_bottom(t_bot)
    );
    always #10 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) i_vds_above_clamp <= 1'($urandom);
    task automatic check(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Random clamp input reaches the output three edges later
    always @(posedge i_ref_clk)
        clamp_hist <= {clamp_hist[1:0], i_vds_above_clamp};
    always @(negedge i_ref_clk)
    begin
        if (!i_sys_rst && gate != 2'h0)
            check(32'(lclamp), 32'(!clamp_hist[2]), "limit clamp");
        if (pg_oe === 1'b1)
            check(32'(pg_out), 32'h0000_0000, "good level");
        if (f_oe === 1'b1)
            check(32'(f_out), 32'h0000_0000, "fault level");
    end
    task automatic print_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Mask and value over {gate, pg_oe, fault_oe, power_limit_set_ground}
    task automatic expect_out(input logic [4:0] m, e);
        notes.push_back({m, e});
        @(posedge i_ref_clk);
    endtask
    always @(negedge i_ref_clk)
    begin
        if (notes.size() != 0)
        begin
            note = notes.pop_front();
            check(32'({gate, pg_oe, f_oe, power_limit_set_gnd} & note[9:5]),
                  32'(note[4:0]), "outputs");
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic wait_gate(input logic [1:0] g, input int lim);
        for (n_wait = 0; n_wait < lim; n_wait++)
        begin
            @(negedge i_ref_clk);
            if (gate === g) break;
        end
        @(posedge i_ref_clk);
        if (n_wait == lim)
        begin
            check(32'(gate), 32'(g), "gate wait");
            print_verdict();
        end
    endtask
    task automatic set_enable(input logic on, latch);
        i_enable_hi <= on;
        i_enable_lo <= !on;
        i_latch_mode <= latch;
        cyc(8);
    endtask
    initial
    begin
        void'($urandom(21672));
        cyc(2);
        i_sys_rst <= 1'b0;
        cyc(8);
        expect_out(5'h07, 5'h01);
        i_por_ok <= 1'b1;
        cyc(8);
        expect_out(5'h07, 5'h01);
        i_supply_low_lockout_ok <= 1'b1;
        wait_gate(2'h3, 10);
        expect_out(5'h07, 5'h00);
        cyc(6);
        expect_out(5'h04, 5'h00);
        cyc(20);
        expect_out(5'h04, 5'h04);
        short_r <= 1'b1;
        cyc(1 + $urandom % 5);
        short_r <= 1'b0;
        cyc(10);
        expect_out(5'h1f, 5'h1c);
        i_excess_voltage <= 1'b1;
        cyc(6);
        expect_out(5'h1a, 5'h12);
        cyc(OV_CYC + 4);
        expect_out(5'h18, 5'h08);
        i_excess_voltage <= 1'b0;
        wait_gate(2'h3, 10);
        expect_out(5'h02, 5'h00);
        i_large_overcur <= 1'b1;
        wait_gate(2'h2, 10);
        i_large_overcur <= 1'b0;
        set_enable(1'b0, 1'b1);
        expect_out(5'h1f, 5'h09);
        set_enable(1'b1, 1'b1);
        short_r <= 1'b1;
        cyc(5);
        @(negedge i_ref_clk);
        check(32'(regl), 32'h0000_0001, "regulate");
        wait_gate(2'h2, 100);
        cyc(40);
        expect_out(5'h1f, 5'h13);
        short_r <= 1'b0;
        set_enable(1'b0, 1'b0);
        expect_out(5'h07, 5'h01);
        i_enable_hi <= 1'b1;
        i_enable_lo <= 1'b0;
        wait_gate(2'h3, 10);
        short_r <= 1'b1;
        wait_gate(2'h2, 100);
        short_r <= 1'b0;
        wait_gate(2'h3, 8000);
        check(32'(n_wait >= 5000), 32'h0000_0001, "retry wait");
        expect_out(5'h02, 5'h00);
        i_supply_low_lockout_ok <= 1'b0;
        cyc(8);
        expect_out(5'h07, 5'h01);
        print_verdict();
    end
endmodule
